// [common/cs_decoder_pkg.sv]
// constants and types for the block chip-select decoder
package cs_decoder_pkg;
  localparam int AREA_COUNT = 4;
  localparam int ADDR_WIDTH = 24;
  localparam int DATA_WIDTH = 8;
  localparam int REG_ADDR_WIDTH = 8;
  localparam int INDEX_WIDTH = 3;

  // register map, byte offsets; area n uses base + 4*n
  localparam logic [7:0] START_BASE = 8'h00;
  localparam logic [7:0] MASK_BASE = 8'h01;
  localparam logic [7:0] CTRL_LOW_BASE = 8'h02;
  localparam logic [7:0] CTRL_HIGH_BASE = 8'h03;
  localparam logic [7:0] EXT_CTRL_LOW = 8'h10;
  localparam logic [7:0] EXT_CTRL_HIGH = 8'h11;
  localparam logic [7:0] STATUS_OFFSET = 8'h12;

  // control low: write waits [6:4], read waits [2:0]
  localparam int WRITE_WAIT_LSB = 4;
  localparam int READ_WAIT_LSB = 0;
  // control high: enable [7], map mode [6], recovery [5], bus width [1:0]
  localparam int ENABLE_BIT = 7;
  localparam int MAP_MODE_BIT = 6;
  localparam int RECOVERY_BIT = 5;
  localparam int BUS_WIDTH_LSB = 0;

  typedef enum logic [2:0] {
    WAIT_ZERO = 3'h1,
    WAIT_ONE = 3'h2,
    WAIT_PIN = 3'h3,
    WAIT_TWO = 3'h5,
    WAIT_THREE = 3'h6,
    WAIT_FOUR = 3'h7
  } wait_code_type;

  typedef enum logic [1:0] {
    BUS_8BIT = 2'h0,
    BUS_16BIT = 2'h1
  } bus_width_type;

  localparam logic [2:0] MIN_STATES = 3'h2;
  localparam logic [1:0] STRAP_16BIT = 2'h1;
  localparam logic [1:0] STRAP_8BIT = 2'h2;

  // reset values of the start, mask and control registers, per area
  localparam logic [7:0] RESET_START = 8'h00;
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [7:0] RESET_CTRL_LOW = 8'h22;
  localparam logic [7:0] RESET_CTRL_HIGH = 8'h00;

  typedef struct packed {
    logic [2:0] write_waits;
    logic [2:0] read_waits;
    logic [1:0] bus_width;
    logic recovery;
    logic map_mode;
    logic enable;
  } area_cfg_type;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic write;
    logic valid;
  } bus_req_type;
endpackage : cs_decoder_pkg

// [rtl/block_chip_select_decoder.sv]
// block chip-select decoder with per-area wait and bus width control
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// Overview of operation
// - four programmable areas plus a default external area
// - read and write wait counts set separately per area
// - six wait modes: fixed zero to four, or wait pin
// - each area selects an 8-bit or 16-bit bus
// - straps sampled at reset release: 01 gives 16-bit, 10 gives 8-bit
// - straps matter only right after reset; later the field rules
// - reset enables area 2 only
// - strapped width is loaded into area 2 bus width field
// - after reset area 2 covers the whole 24-bit space
// - each cycle compare address with start, skipping masked bits
// - a match drives that area's chip-select low
// - start field is A23..A16, lower bits zero, 64K granularity
// - mask bit 0 compares, 1 ignores
// - maskable: area0 A20..A8, area1 A21..A8, areas 2,3 A22..A15
// - bits above the maskable range are always compared
// - area 2 map mode 0 spans all, 1 uses start and mask
// - priority: internal io, internal memory, areas 0..3, default
// - unmatched accesses use the default area settings
// - wait codes 001,010,101,110,111 fixed, 011 wait pin
// - wait-pin cycle lasts at least four states, extends while wait is low
// - bus width 00 is 8-bit, 01 is 16-bit
// ----------------------------------------------------------------------------
module block_chip_select_decoder
  import cs_decoder_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [REG_ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic [DATA_WIDTH-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [DATA_WIDTH-1:0] reg_rdata_out,
  input wire logic bus_valid_in,
  input wire logic bus_write_in,
  input wire logic [ADDR_WIDTH-1:0] bus_addr_in,
  input wire logic internal_io_hit_in,
  input wire logic internal_mem_hit_in,
  input wire logic wait_n_in,
  input wire logic bus_width_strap_hi_in,
  input wire logic bus_width_strap_lo_in,
  output logic [AREA_COUNT-1:0] chip_select_n_out,
  output logic default_external_area_out,
  output logic bus_16bit_out,
  output logic recovery_out,
  output logic bus_busy_out,
  output logic bus_done_out
);

  // --------------------------------------------------------------------------
  // synchronisers for pins
  // --------------------------------------------------------------------------
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic wait_n_sync;
  logic [1:0] strap_sync;

  // no reset: the straps must already be through both stages at reset release
  always_ff @(posedge mclk_in) begin
    pin_meta_reg <= {wait_n_in, bus_width_strap_hi_in, bus_width_strap_lo_in};
    pin_sync_reg <= pin_meta_reg;
  end
  assign wait_n_sync = pin_sync_reg[2];
  assign strap_sync = pin_sync_reg[1:0];

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  logic [7:0] start_reg [AREA_COUNT];
  logic [7:0] start_next [AREA_COUNT];
  logic [7:0] mask_reg [AREA_COUNT];
  logic [7:0] mask_next [AREA_COUNT];
  area_cfg_type cfg_reg [AREA_COUNT+1];
  area_cfg_type cfg_next [AREA_COUNT+1];
  logic strap_done_reg;
  logic strap_done_next;
  logic strap_bad_reg;
  logic strap_bad_next;
  logic [DATA_WIDTH-1:0] rdata_reg;
  logic [DATA_WIDTH-1:0] rdata_next;
  logic [7:0] status_byte;

  function automatic logic [7:0] area_offset(input logic [7:0] base, input int idx);
    area_offset = base + 8'(idx * 4);
  endfunction

  function automatic area_cfg_type cfg_from_bytes(input logic [7:0] low, input logic [7:0] high);
    area_cfg_type c;
    c.write_waits = low[WRITE_WAIT_LSB +: 3];
    c.read_waits = low[READ_WAIT_LSB +: 3];
    c.enable = high[ENABLE_BIT];
    c.map_mode = high[MAP_MODE_BIT];
    c.recovery = high[RECOVERY_BIT];
    c.bus_width = high[BUS_WIDTH_LSB +: 2];
    cfg_from_bytes = c;
  endfunction

  function automatic logic [7:0] cfg_low_byte(input area_cfg_type c);
    logic [7:0] b;
    b = 8'h00;
    b[WRITE_WAIT_LSB +: 3] = c.write_waits;
    b[READ_WAIT_LSB +: 3] = c.read_waits;
    cfg_low_byte = b;
  endfunction

  function automatic logic [7:0] cfg_high_byte(input area_cfg_type c);
    logic [7:0] b;
    b = 8'h00;
    b[ENABLE_BIT] = c.enable;
    b[MAP_MODE_BIT] = c.map_mode;
    b[RECOVERY_BIT] = c.recovery;
    b[BUS_WIDTH_LSB +: 2] = c.bus_width;
    cfg_high_byte = b;
  endfunction

  // slot AREA_COUNT is the default external area
  function automatic logic [7:0] ctrl_low_addr(input int idx);
    ctrl_low_addr = (idx == AREA_COUNT) ? EXT_CTRL_LOW : area_offset(CTRL_LOW_BASE, idx);
  endfunction

  function automatic logic [7:0] ctrl_high_addr(input int idx);
    ctrl_high_addr = (idx == AREA_COUNT) ? EXT_CTRL_HIGH : area_offset(CTRL_HIGH_BASE, idx);
  endfunction

  assign status_byte = {5'h00, strap_bad_reg, strap_done_reg, bus_busy_out};

  always_comb begin
    strap_done_next = strap_done_reg;
    strap_bad_next = strap_bad_reg;
    rdata_next = 8'h00;
    for (int i = 0; i < AREA_COUNT; i++) begin
      start_next[i] = start_reg[i];
      mask_next[i] = mask_reg[i];
    end
    for (int i = 0; i <= AREA_COUNT; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (reg_write_in) begin
      for (int i = 0; i < AREA_COUNT; i++) begin
        if (reg_addr_in == area_offset(START_BASE, i)) start_next[i] = reg_wdata_in;
        if (reg_addr_in == area_offset(MASK_BASE, i)) mask_next[i] = reg_wdata_in;
      end
      for (int i = 0; i <= AREA_COUNT; i++) begin
        if (reg_addr_in == ctrl_low_addr(i)) begin
          cfg_next[i] = cfg_from_bytes(reg_wdata_in, cfg_high_byte(cfg_reg[i]));
        end
        if (reg_addr_in == ctrl_high_addr(i)) begin
          cfg_next[i] = cfg_from_bytes(cfg_low_byte(cfg_reg[i]), reg_wdata_in);
        end
      end
    end
    // straps taken once, first clock after release, into area 2 width
    if (!strap_done_reg) begin
      strap_done_next = 1'b1;
      strap_bad_next = (strap_sync != STRAP_16BIT) && (strap_sync != STRAP_8BIT);
      cfg_next[2].bus_width = (strap_sync == STRAP_16BIT) ? BUS_16BIT : BUS_8BIT;
    end
    if (reg_read_in) begin
      for (int i = 0; i < AREA_COUNT; i++) begin
        if (reg_addr_in == area_offset(START_BASE, i)) rdata_next = start_reg[i];
        if (reg_addr_in == area_offset(MASK_BASE, i)) rdata_next = mask_reg[i];
      end
      for (int i = 0; i <= AREA_COUNT; i++) begin
        if (reg_addr_in == ctrl_low_addr(i)) rdata_next = cfg_low_byte(cfg_reg[i]);
        if (reg_addr_in == ctrl_high_addr(i)) rdata_next = cfg_high_byte(cfg_reg[i]);
      end
      if (reg_addr_in == STATUS_OFFSET) rdata_next = status_byte;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < AREA_COUNT; i++) begin
        start_reg[i] <= RESET_START;
        mask_reg[i] <= RESET_MASK;
      end
      for (int i = 0; i <= AREA_COUNT; i++) begin
        cfg_reg[i] <= cfg_from_bytes(RESET_CTRL_LOW, RESET_CTRL_HIGH);
      end
      cfg_reg[2].enable <= 1'b1;
      strap_done_reg <= 1'b0;
      strap_bad_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      start_reg <= start_next;
      mask_reg <= mask_next;
      cfg_reg <= cfg_next;
      strap_done_reg <= strap_done_next;
      strap_bad_reg <= strap_bad_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_out = rdata_reg;

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  // builds a 24-bit ignore mask from the 8-bit mask register
  function automatic logic [ADDR_WIDTH-1:0] ignore_bits(input int idx, input logic [7:0] m);
    logic [ADDR_WIDTH-1:0] ig;
    ig = '0;
    case (idx)
      0: begin
        ig[20:16] = m[4:0];
        ig[15:9] = {7{m[5]}};
        ig[8] = m[6];
      end
      1: begin
        ig[21:16] = m[7:2];
        ig[15:9] = {7{m[1]}};
        ig[8] = m[0];
      end
      default: ig[22:15] = m;
    endcase
    // unmaskable low bits below the range are don't care
    if (idx >= 2) ig[14:0] = '1;
    else ig[7:0] = '1;
    ignore_bits = ig;
  endfunction

  logic [AREA_COUNT-1:0] area_match;
  logic [AREA_COUNT-1:0] area_sel;
  logic ext_sel;
  logic [INDEX_WIDTH-1:0] sel_index;
  logic [ADDR_WIDTH-1:0] start_full;
  logic [ADDR_WIDTH-1:0] ignore_full;

  always_comb begin
    area_match = '0;
    start_full = '0;
    ignore_full = '0;
    for (int i = 0; i < AREA_COUNT; i++) begin
      start_full = {start_reg[i], 16'h0000};
      ignore_full = ignore_bits(i, mask_reg[i]);
      area_match[i] = cfg_reg[i].enable &&
        (((bus_addr_in ^ start_full) & ~ignore_full) == '0);
      if (i == 2 && !cfg_reg[i].map_mode) area_match[i] = cfg_reg[i].enable;
    end
    area_sel = '0;
    ext_sel = 1'b0;
    sel_index = INDEX_WIDTH'(AREA_COUNT);
    if (!internal_io_hit_in && !internal_mem_hit_in) begin
      ext_sel = 1'b1;
      for (int i = AREA_COUNT - 1; i >= 0; i--) begin
        if (area_match[i]) sel_index = INDEX_WIDTH'(i);
      end
      if (sel_index != INDEX_WIDTH'(AREA_COUNT)) begin
        area_sel[sel_index[1:0]] = 1'b1;
        ext_sel = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // bus cycle timing
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    ACTIVE = 2'b01
  } cycle_state_type;

  localparam logic [2:0] SYNC_LAG = 3'h2;

  function automatic logic [2:0] fixed_states(input logic [2:0] code);
    case (code)
      WAIT_ZERO: fixed_states = 3'h2;
      WAIT_TWO: fixed_states = 3'h4;
      WAIT_THREE: fixed_states = 3'h5;
      WAIT_FOUR: fixed_states = 3'h6;
      default: fixed_states = 3'h3;
    endcase
  endfunction

  cycle_state_type state_reg;
  cycle_state_type state_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [2:0] target_reg;
  logic [2:0] target_next;
  logic pin_mode_reg;
  logic pin_mode_next;
  logic [AREA_COUNT-1:0] cs_n_reg;
  logic [AREA_COUNT-1:0] cs_n_next;
  logic ext_reg;
  logic ext_next;
  logic wide_reg;
  logic wide_next;
  logic rec_reg;
  logic rec_next;
  logic done_reg;
  logic done_next;
  logic [2:0] wait_code;
  area_cfg_type sel_cfg;

  always_comb begin
    sel_cfg = cfg_reg[sel_index];
    wait_code = bus_write_in ? sel_cfg.write_waits : sel_cfg.read_waits;
    state_next = state_reg;
    count_next = count_reg;
    target_next = target_reg;
    pin_mode_next = pin_mode_reg;
    cs_n_next = cs_n_reg;
    ext_next = ext_reg;
    wide_next = wide_reg;
    rec_next = rec_reg;
    done_next = 1'b0;
    case (state_reg)
      IDLE: begin
        // valid still stands at the done edge; taking it would start a phantom cycle
        if (bus_valid_in && !done_reg && (ext_sel || area_sel != '0)) begin
          state_next = ACTIVE;
          count_next = 3'h1;
          pin_mode_next = (wait_code == WAIT_PIN);
          // the pin reaches wait_n_sync two clocks late, so pin mode lasts longer
          target_next = (wait_code == WAIT_PIN) ? (MIN_STATES + SYNC_LAG) :
            fixed_states(wait_code);
          cs_n_next = ~area_sel;
          ext_next = ext_sel;
          wide_next = (sel_cfg.bus_width == BUS_16BIT);
          rec_next = sel_cfg.recovery;
        end
      end
      ACTIVE: begin
        if (count_reg >= target_reg && (!pin_mode_reg || wait_n_sync)) begin
          state_next = IDLE;
          done_next = 1'b1;
          cs_n_next = '1;
          ext_next = 1'b0;
          wide_next = 1'b0;
          rec_next = 1'b0;
        end else if (count_reg < target_reg) begin
          count_next = count_reg + 3'h1;
        end
      end
      default: state_next = IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= IDLE;
      count_reg <= 3'h0;
      target_reg <= 3'h0;
      pin_mode_reg <= 1'b0;
      cs_n_reg <= '1;
      ext_reg <= 1'b0;
      wide_reg <= 1'b0;
      rec_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      target_reg <= target_next;
      pin_mode_reg <= pin_mode_next;
      cs_n_reg <= cs_n_next;
      ext_reg <= ext_next;
      wide_reg <= wide_next;
      rec_reg <= rec_next;
      done_reg <= done_next;
    end
  end

  assign chip_select_n_out = cs_n_reg;
  assign default_external_area_out = ext_reg;
  assign bus_16bit_out = wide_reg;
  assign recovery_out = rec_reg;
  assign bus_busy_out = (state_reg == ACTIVE);
  assign bus_done_out = done_reg;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  sequence start_seq;
    state_reg == IDLE && bus_valid_in && !bus_done_out && (ext_sel || area_sel != '0);
  endsequence

  AST_ONE_HOT_CS: assert property (@(posedge mclk_in) disable iff (rst_in)
    $countones(~chip_select_n_out) <= 1)
    else $error("more than one chip-select low");
  AST_CS_MATCH: assert property (@(posedge mclk_in) disable iff (rst_in)
    start_seq ##0 (area_sel[0]) |=> !chip_select_n_out[0])
    else $error("area 0 select not driven low");
  AST_MIN_TWO: assert property (@(posedge mclk_in) disable iff (rst_in)
    start_seq |=> !bus_done_out ##1 !bus_done_out)
    else $error("bus cycle shorter than two states");
  AST_ZERO_WAIT: assert property (@(posedge mclk_in) disable iff (rst_in)
    start_seq ##0 (wait_code == WAIT_ZERO) |=> ##2 bus_done_out)
    else $error("zero wait cycle wrong length");
  AST_FOUR_WAIT: assert property (@(posedge mclk_in) disable iff (rst_in)
    start_seq ##0 (wait_code == WAIT_FOUR) |=> !bus_done_out [*6] ##1 bus_done_out)
    else $error("four wait cycle wrong length");
  AST_PIN_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    bus_busy_out && pin_mode_reg && !wait_n_sync |=> !bus_done_out)
    else $error("cycle ended while wait active");
  AST_PRIORITY: assert property (@(posedge mclk_in) disable iff (rst_in)
    (internal_io_hit_in || internal_mem_hit_in) |-> (area_sel == '0 && !ext_sel))
    else $error("external select during internal access");
  AST_AREA2_RESET: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_reg[2].enable && !cfg_reg[2].map_mode && !internal_io_hit_in && !internal_mem_hit_in
    && area_match[1:0] == '0 |-> area_sel[2])
    else $error("area 2 not covering whole space");
  AST_STRAP: assert property (@(posedge mclk_in) disable iff (rst_in)
    !strap_done_reg && strap_sync == STRAP_16BIT |=> cfg_reg[2].bus_width == BUS_16BIT)
    else $error("strap width not loaded");

endmodule : block_chip_select_decoder
`default_nettype wire

// [verif/ext_memory_model.sv]
// external memory model that drives the wait pin of the selected device
`timescale 1ns/1ns
`default_nettype none
module ext_memory_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [3:0] chip_select_n_in,
  input wire logic [7:0] slow_cycles_in,
  output logic wait_n_out
);
  logic [7:0] hold_reg;
  logic [7:0] hold_next;

  // ---------------------------------------------------------------
  // cycles since the device was selected
  // ---------------------------------------------------------------
  always_comb begin
    hold_next = hold_reg;
    if (&chip_select_n_in) begin
      hold_next = 8'h00;
    end else if (hold_reg != 8'hFF) begin
      hold_next = hold_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_reg <= 8'h00;
    end else begin
      hold_reg <= hold_next;
    end
  end

  // pull-up holds the line high while nothing is selected
  assign wait_n_out = (&chip_select_n_in) || (hold_reg >= slow_cycles_in);
endmodule // ext_memory_model
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the block chip-select decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  import cs_decoder_pkg::*;
  typedef struct packed {
    logic [23:0] addr;
    logic wr;
    logic [3:0] cs;
    logic [3:0] len;
    logic w16;
  } row_type;
  localparam logic [7:0] AREA2_HIGH = CTRL_HIGH_BASE + 8'h08;
  logic mclk_in, rst_in, reg_write_in, reg_read_in, bus_valid_in, bus_write_in;
  logic io_hit, mem_hit, wait_n, strap_hi, strap_lo, dflt, w16, busy, done;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, slow;
  logic [23:0] bus_addr_in;
  logic [3:0] cs_n;
  logic rec;
  logic rec_exp = 1'h0;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  // area 0 at 0x110000, 512 bytes, read 2 states, write 6 states, 8-bit
  row_type rows [5] = '{'{24'h110000, 1'h0, 4'hE, 4'h2, 1'h0},
                        '{24'h1101FF, 1'h1, 4'hE, 4'h6, 1'h0},
                        '{24'h110200, 1'h0, 4'hB, 4'h3, 1'h1},
                        '{24'h910000, 1'h1, 4'hB, 4'h3, 1'h1},
                        '{24'h000000, 1'h0, 4'hB, 4'h3, 1'h1}};
  // reserved code 000 falls back to the one-wait default
  logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0};
  int lens [6] = '{2, 3, 4, 5, 6, 3};

  block_chip_select_decoder u_dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .bus_valid_in(bus_valid_in), .bus_write_in(bus_write_in),
    .bus_addr_in(bus_addr_in), .internal_io_hit_in(io_hit), .internal_mem_hit_in(mem_hit),
    .wait_n_in(wait_n), .bus_width_strap_hi_in(strap_hi), .bus_width_strap_lo_in(strap_lo),
    .chip_select_n_out(cs_n), .default_external_area_out(dflt), .bus_16bit_out(w16),
    .recovery_out(rec), .bus_busy_out(busy), .bus_done_out(done));

  ext_memory_model u_mem (
    .mclk_in(mclk_in), .rst_in(rst_in), .chip_select_n_in(cs_n),
    .slow_cycles_in(slow), .wait_n_out(wait_n));

  initial begin
    mclk_in = 1'h0;
    forever #4 mclk_in = ~mclk_in;
  end

  // ---------------------------------------------------------------
  // compare and report
  // ---------------------------------------------------------------
  task automatic check_reg(input string name, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_sel(input string name, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic check_flag(input string name, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask
  task automatic check_len(input string name, input int e, input int g);
    samples_checked++;
    if (g != e) begin
      fail_count++;
      $display("mismatch %s expected %0d seen %0d", name, e, g);
    end
  endtask
  task automatic test_end(input string name);
    $display("test %s finished, mismatches so far %0d", name, fail_count);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // register bus and cpu bus cycles
  // ---------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'h1;
    @(posedge mclk_in);
    reg_write_in <= 1'h0;
  endtask
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e, input string name);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'h1;
    @(posedge mclk_in);
    reg_read_in <= 1'h0;
    #1;
    check_reg(name, e, reg_rdata_out);
  endtask
  // len 0 leaves the length to the caller
  task automatic bus_cycle(input logic [23:0] a, input logic wr, input logic [3:0] cs,
                           input int len, input logic wide, input logic dfl, output int cnt);
    bit seen;
    logic [3:0] cs_hold;
    seen = 1'b0;
    cs_hold = 4'hF;
    cnt = 0;
    @(posedge mclk_in);
    bus_addr_in <= a;
    bus_write_in <= wr;
    bus_valid_in <= 1'h1;
    while (!seen && cnt < 40) begin
      @(posedge mclk_in);
      #1;
      cnt++;
      seen = (done === 1'h1);
      // width, area and recovery drop together with the done pulse
      if (cnt == 1) begin
        check_sel("cs_first", cs, cs_n);
        check_flag("width16", wide, w16);
        check_flag("default_area", dfl, dflt);
        check_flag("recovery", rec_exp, rec);
      end
      if (!seen) cs_hold = cs_n;
    end
    if (!seen) begin
      fail_count++;
      $display("mismatch bus_done expected 1 seen timeout");
      results();
    end else begin
      check_sel("cs_last", cs, cs_hold);
      if (len > 0) check_len("states", len, cnt - 1);
      @(posedge mclk_in);
      bus_valid_in <= 1'h0;
      @(posedge mclk_in);
      #1;
      check_sel("cs_idle", 4'hF, cs_n);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_in = 1'h1;
    {reg_write_in, reg_read_in, bus_valid_in, bus_write_in, io_hit, mem_hit} = 6'h00;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    bus_addr_in = 24'h000000;
    slow = 8'h00;
    strap_hi = 1'h0;
    strap_lo = 1'h1;
    @(posedge mclk_in);
    #1;
    check_sel("cs_reset", 4'hF, cs_n);
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'h0;
    repeat (4) @(posedge mclk_in);
    strap_hi <= 1'h1;
    strap_lo <= 1'h0;
    reg_chk(AREA2_HIGH, 8'h81, "area2_ctrl_high");
    reg_chk(CTRL_HIGH_BASE, 8'h00, "area0_ctrl_high");
    reg_chk(CTRL_LOW_BASE, RESET_CTRL_LOW, "area0_ctrl_low");
    reg_chk(STATUS_OFFSET, 8'h02, "status_strap_ok");
    reg_wr(8'hF0, 8'h5A);
    reg_chk(8'hF0, 8'h00, "unmapped");
    test_end("reset");
    bus_cycle(24'h000000, 1'h0, 4'hB, 3, 1'h1, 1'h0, n);
    bus_cycle(24'hFFFFFF, 1'h1, 4'hB, 3, 1'h1, 1'h0, n);
    test_end("whole_space");
    reg_wr(START_BASE, 8'h11);
    reg_wr(MASK_BASE, 8'h40);
    reg_wr(CTRL_LOW_BASE, 8'h71);
    reg_wr(CTRL_HIGH_BASE, 8'h80);
    reg_chk(START_BASE, 8'h11, "area0_start");
    foreach (rows[i]) begin
      bus_cycle(rows[i].addr, rows[i].wr, rows[i].cs, int'(rows[i].len), rows[i].w16, 1'h0, n);
    end
    reg_wr(CTRL_HIGH_BASE, 8'hA0);
    rec_exp = 1'h1;
    bus_cycle(24'h110100, 1'h0, 4'hE, 2, 1'h0, 1'h0, n);
    rec_exp = 1'h0;
    reg_wr(CTRL_HIGH_BASE, 8'h80);
    test_end("decode_table");
    foreach (codes[i]) begin
      reg_wr(CTRL_LOW_BASE, {5'h0E, codes[i]});
      bus_cycle(24'h110010, 1'h0, 4'hE, lens[i], 1'h0, 1'h0, n);
    end
    test_end("wait_codes");
    reg_wr(CTRL_LOW_BASE, 8'h73);
    bus_cycle(24'h110004, 1'h0, 4'hE, 4, 1'h0, 1'h0, n);
    slow <= 8'h06;
    bus_cycle(24'h110008, 1'h0, 4'hE, 0, 1'h0, 1'h0, n);
    check_flag("pin_stretch", 1'h1, n >= 6 && n <= 10);
    slow <= 8'h00;
    test_end("wait_pin");
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_in);
      io_hit <= (k == 0);
      mem_hit <= (k == 1);
      bus_addr_in <= 24'h110000;
      bus_valid_in <= 1'h1;
      repeat (4) begin
        @(posedge mclk_in);
        #1;
        check_sel("cs_internal", 4'hF, cs_n);
        check_flag("busy_internal", 1'h0, busy);
      end
      @(posedge mclk_in);
      bus_valid_in <= 1'h0;
      io_hit <= 1'h0;
      mem_hit <= 1'h0;
    end
    test_end("internal_priority");
    reg_wr(AREA2_HIGH, 8'h01);
    bus_cycle(24'h200000, 1'h0, 4'hF, 3, 1'h0, 1'h1, n);
    test_end("default_area");
    reg_wr(START_BASE + 8'h04, 8'h11);
    reg_wr(MASK_BASE + 8'h04, 8'h03);
    reg_wr(CTRL_HIGH_BASE + 8'h04, 8'h80);
    bus_cycle(24'h110000, 1'h1, 4'hE, 6, 1'h0, 1'h0, n);
    bus_cycle(24'h118000, 1'h0, 4'hD, 3, 1'h0, 1'h0, n);
    test_end("area_overlap");
    reg_wr(START_BASE + 8'h08, 8'h80);
    reg_wr(AREA2_HIGH, 8'hC0);
    bus_cycle(24'h800000, 1'h0, 4'hB, 3, 1'h0, 1'h0, n);
    bus_cycle(24'h808000, 1'h0, 4'hF, 3, 1'h0, 1'h1, n);
    test_end("area2_mapped");
    // second reset with the 8-bit strap pattern
    @(posedge mclk_in);
    rst_in <= 1'h1;
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'h0;
    repeat (4) @(posedge mclk_in);
    reg_chk(AREA2_HIGH, 8'h80, "area2_width8");
    reg_chk(CTRL_HIGH_BASE, 8'h00, "area0_off");
    bus_cycle(24'h123456, 1'h0, 4'hB, 3, 1'h0, 1'h0, n);
    test_end("strap_8bit");
    results();
  end
endmodule // tb
`default_nettype wire
